// ==== logic/vacr_regs.sv ====
// vacr_regs: configuration register bank and link watchdog of the actuator
`timescale 1ns/1ps
`default_nettype none
module vacr_regs #(
  parameter int TICK_CYCLES = vacr_pkg::TICK_CYCLES,
  parameter logic [15:0] FLOW_M3H = 16'h0000
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // register access from the protocol engine
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  // supervised writes (setpoint, forced position)
  input wire logic setpoint_wr_in,
  input wire logic force_wr_in,
  // nominal flow in each unit, 0.001 scaling, index = unit code
  input wire logic [31:0] flow_by_unit_in [7],
  // other malfunction bits from the actuator core
  input wire logic [15:0] fault_bits_in,
  // configuration, link-loss flag and status word to the control core
  output logic [2:0] sensor_type_out,
  output logic [1:0] loss_target_out,
  output logic flow_mode_out,
  output logic [2:0] flow_unit_out,
  output logic bus_source_out,
  output logic comm_lost_out,
  output logic [15:0] status_out
);
  logic [15:0] sensor_r;
  logic [15:0] loss_r;
  logic [15:0] timeout_r;
  logic timeout_written_r;
  logic [15:0] mode_r;
  logic [15:0] unit_r;
  logic [15:0] source_r;
  logic [15:0] wd_cnt_r;
  logic wd_fired_r;
  logic tick;
  logic restart;
  logic [15:0] timeout_eff;
  logic [31:0] flow_sel;

  vacr_tick #(.PERIOD(TICK_CYCLES)) u_tick (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .tick_out(tick)
  );

  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction : hit

  // legal sensor codes; 2 and 3 are reserved and never stored
  function automatic logic sensor_ok(input logic [15:0] v);
    return v == 16'h0000 || v == 16'h0001 || v == 16'h0004;
  endfunction : sensor_ok

  wire wr_sensor = wr_en_in && hit(addr_in, vacr_pkg::ADDR_SENSOR);
  wire wr_loss = wr_en_in && hit(addr_in, vacr_pkg::ADDR_LOSS);
  wire wr_timeout = wr_en_in && hit(addr_in, vacr_pkg::ADDR_TIMEOUT);
  wire wr_mode = wr_en_in && hit(addr_in, vacr_pkg::ADDR_MODE);
  wire wr_unit = wr_en_in && hit(addr_in, vacr_pkg::ADDR_UNIT);
  wire wr_source = wr_en_in && hit(addr_in, vacr_pkg::ADDR_SOURCE);

  // sensor type: only 0, 1 and 4 are legal, others dropped
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      sensor_r <= vacr_pkg::SENSOR_RST; // R01
    end else if (wr_sensor && sensor_ok(wdata_in)) begin
      sensor_r <= wdata_in; // R01
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      loss_r <= vacr_pkg::LOSS_RST; // R04
    end else if (wr_loss && wdata_in <= vacr_pkg::LOSS_MAX) begin
      loss_r <= wdata_in; // R04
    end
  end

  // out-of-range timeouts are ignored rather than clipped
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      timeout_r <= vacr_pkg::TIMEOUT_RST;
      timeout_written_r <= 1'b0;
    end else if (wr_timeout && wdata_in <= vacr_pkg::TIMEOUT_MAX) begin
      timeout_r <= wdata_in; // R07
      timeout_written_r <= 1'b1;
    end
  end

  // until software sets a timeout, a non-hold target implies 120 s
  assign timeout_eff = (!timeout_written_r && loss_r != vacr_pkg::LOSS_RST)
                       ? vacr_pkg::TIMEOUT_ACTIVE_DEF : timeout_r; // R08

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      mode_r <= vacr_pkg::MODE_RST;
    end else if (wr_mode && wdata_in <= 16'h0001) begin
      mode_r <= wdata_in; // R11
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      unit_r <= vacr_pkg::UNIT_RST; // R12
    end else if (wr_unit && wdata_in <= vacr_pkg::UNIT_MAX) begin
      unit_r <= wdata_in; // R12
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      source_r <= vacr_pkg::SOURCE_RST; // R13
    end else if (wr_source && wdata_in <= 16'h0001) begin
      source_r <= wdata_in; // R13
    end
  end

  // watchdog: counts seconds since last supervised write
  assign restart = setpoint_wr_in || force_wr_in;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || restart || timeout_eff == 16'h0000) begin
      wd_cnt_r <= 16'h0000; // R16
    end else if (tick && wd_cnt_r < timeout_eff) begin
      wd_cnt_r <= wd_cnt_r + 16'h0001; // R16
    end
  end

  // a restart clears the loss state; zero timeout never fires
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || restart || timeout_eff == 16'h0000) begin
      wd_fired_r <= 1'b0; // R02 R07
    end else if (wd_cnt_r >= timeout_eff) begin
      wd_fired_r <= 1'b1; // R03
    end
  end

  // flow words follow the live unit selection, no latching
  assign flow_sel = flow_by_unit_in[unit_r[2:0]]; // R10

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      rdata_out <= 16'h0000;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= rd_en_in;
      if (rd_en_in) begin
        case (addr_in)
          vacr_pkg::ADDR_STATUS: rdata_out <= status_out;
          vacr_pkg::ADDR_SENSOR: rdata_out <= sensor_r;
          vacr_pkg::ADDR_LOSS: rdata_out <= loss_r;
          vacr_pkg::ADDR_TIMEOUT: rdata_out <= timeout_eff;
          vacr_pkg::ADDR_FLOW_M3H: rdata_out <= FLOW_M3H; // R14
          vacr_pkg::ADDR_FLOW_LO: rdata_out <= flow_sel[15:0]; // R09
          vacr_pkg::ADDR_FLOW_HI: rdata_out <= flow_sel[31:16]; // R09
          vacr_pkg::ADDR_MODE: rdata_out <= mode_r;
          vacr_pkg::ADDR_UNIT: rdata_out <= unit_r;
          vacr_pkg::ADDR_SOURCE: rdata_out <= source_r;
          default: rdata_out <= 16'h0000; // R15
        endcase
      end
    end
  end

  always_comb begin
    status_out = fault_bits_in;
    status_out[vacr_pkg::WDOG_BIT] = wd_fired_r; // R05 R06
  end

  assign sensor_type_out = sensor_r[2:0];
  assign loss_target_out = loss_r[1:0];
  assign flow_mode_out = mode_r[0];
  assign flow_unit_out = unit_r[2:0];
  assign bus_source_out = source_r[0];
  // hold target means keep last setpoint even when fired
  assign comm_lost_out = wd_fired_r && loss_r != vacr_pkg::LOSS_RST; // R02 R03

  // reset state
  sens_reset_a: assert property ( // R01
    @(posedge core_clk_in)
    $rose(reset_n_in)
    |-> sensor_r == 16'h0000 && unit_r == 16'h0001 && source_r == 16'h0001)
    else $error("reset values wrong");

  loss_reset_a: assert property ( // R04
    @(posedge core_clk_in)
    $rose(reset_n_in)
    |-> loss_r == 16'h0000 && timeout_r == 16'h0000 && !wd_fired_r)
    else $error("loss or timeout reset wrong");

  // watchdog
  wd_off_a: assert property ( // R07
    @(posedge core_clk_in) disable iff (!reset_n_in)
    timeout_eff == 16'h0000
    |=> !wd_fired_r)
    else $error("disabled watchdog fired");

  wd_bit_a: assert property ( // R06
    @(posedge core_clk_in) disable iff (!reset_n_in)
    1'b1
    |-> status_out[10] == wd_fired_r)
    else $error("status bit 10 mismatch");

  fault_pass_a: assert property ( // R06
    @(posedge core_clk_in) disable iff (!reset_n_in)
    1'b1
    |-> ((status_out ^ fault_bits_in) & 16'hfbff) == 16'h0000)
    else $error("other status bits altered");

  wd_fire_a: assert property ( // R05
    @(posedge core_clk_in) disable iff (!reset_n_in)
    wd_cnt_r >= timeout_eff && timeout_eff != 16'h0000 && !restart
    |=> wd_fired_r)
    else $error("watchdog did not fire");

  wd_restart_a: assert property ( // R03
    @(posedge core_clk_in) disable iff (!reset_n_in)
    restart
    |=> wd_cnt_r == 16'h0000 && !wd_fired_r)
    else $error("restart ignored");

  lost_flag_a: assert property ( // R03
    @(posedge core_clk_in) disable iff (!reset_n_in)
    comm_lost_out
    |-> status_out[10])
    else $error("loss action without status flag");

  hold_last_a: assert property ( // R02
    @(posedge core_clk_in) disable iff (!reset_n_in)
    loss_r == 16'h0000
    |-> !comm_lost_out)
    else $error("hold target left setpoint");

  tick_step_a: assert property ( // R16
    @(posedge core_clk_in) disable iff (!reset_n_in)
    tick && !restart && timeout_eff != 16'h0000 && wd_cnt_r < timeout_eff
    |=> wd_cnt_r == $past(wd_cnt_r) + 16'h0001)
    else $error("watchdog missed a tick");

  tick_hold_a: assert property ( // R16
    @(posedge core_clk_in) disable iff (!reset_n_in)
    !tick && !restart && timeout_eff != 16'h0000
    |=> $stable(wd_cnt_r))
    else $error("watchdog moved without tick");

  // timeout register
  def_120_a: assert property ( // R08
    @(posedge core_clk_in) disable iff (!reset_n_in)
    !timeout_written_r && loss_r != 16'h0000
    |-> timeout_eff == 16'h0078)
    else $error("default timeout not 120");

  tmo_wr_a: assert property ( // R07
    @(posedge core_clk_in) disable iff (!reset_n_in)
    wr_timeout && wdata_in <= 16'h0e10
    |=> timeout_r == $past(wdata_in))
    else $error("timeout write lost");

  tmo_bad_a: assert property ( // R07
    @(posedge core_clk_in) disable iff (!reset_n_in)
    wr_timeout && wdata_in > 16'h0e10
    |=> $stable(timeout_r))
    else $error("timeout above limit taken");

  // configuration registers
  sens_wr_a: assert property ( // R01
    @(posedge core_clk_in) disable iff (!reset_n_in)
    wr_sensor && sensor_ok(wdata_in)
    |=> sensor_r == $past(wdata_in))
    else $error("sensor write lost");

  sens_bad_a: assert property ( // R01
    @(posedge core_clk_in) disable iff (!reset_n_in)
    wr_sensor && !sensor_ok(wdata_in)
    |=> $stable(sensor_r))
    else $error("reserved sensor code taken");

  loss_wr_a: assert property ( // R04
    @(posedge core_clk_in) disable iff (!reset_n_in)
    wr_loss && wdata_in <= 16'h0003
    |=> loss_r == $past(wdata_in))
    else $error("loss target write lost");

  loss_bad_a: assert property ( // R04
    @(posedge core_clk_in) disable iff (!reset_n_in)
    wr_loss && wdata_in > 16'h0003
    |=> $stable(loss_r))
    else $error("bad loss target taken");

  mode_wr_a: assert property ( // R11
    @(posedge core_clk_in) disable iff (!reset_n_in)
    wr_mode && wdata_in <= 16'h0001
    |=> flow_mode_out == $past(wdata_in[0]))
    else $error("mode write lost");

  mode_bad_a: assert property ( // R11
    @(posedge core_clk_in) disable iff (!reset_n_in)
    wr_mode && wdata_in > 16'h0001
    |=> $stable(mode_r))
    else $error("bad mode taken");

  unit_bad_a: assert property ( // R12
    @(posedge core_clk_in) disable iff (!reset_n_in)
    wr_unit && wdata_in > 16'h0006
    |=> $stable(unit_r))
    else $error("bad unit taken");

  src_wr_a: assert property ( // R13
    @(posedge core_clk_in) disable iff (!reset_n_in)
    wr_source && wdata_in <= 16'h0001
    |=> bus_source_out == $past(wdata_in[0]))
    else $error("source write lost");

  src_bad_a: assert property ( // R13
    @(posedge core_clk_in) disable iff (!reset_n_in)
    wr_source && wdata_in > 16'h0001
    |=> $stable(source_r))
    else $error("bad source taken");

  // reads and unmapped addresses
  rd_valid_a: assert property ( // R09
    @(posedge core_clk_in) disable iff (!reset_n_in)
    rd_en_in
    |=> rvalid_out)
    else $error("read not answered");

  rd_quiet_a: assert property ( // R09
    @(posedge core_clk_in) disable iff (!reset_n_in)
    !rd_en_in
    |=> !rvalid_out)
    else $error("answer without read");

  flow_lo_a: assert property ( // R09
    @(posedge core_clk_in) disable iff (!reset_n_in)
    rd_en_in && addr_in == 16'h0070
    |=> rdata_out == $past(flow_sel[15:0]))
    else $error("flow low word wrong");

  flow_hi_a: assert property ( // R10
    @(posedge core_clk_in) disable iff (!reset_n_in)
    rd_en_in && addr_in == 16'h0071
    |=> rdata_out == $past(flow_sel[31:16]))
    else $error("flow high word wrong");

  flow_m3h_a: assert property ( // R14
    @(posedge core_clk_in) disable iff (!reset_n_in)
    rd_en_in && addr_in == 16'h006e
    |=> rdata_out == FLOW_M3H)
    else $error("m3h flow word wrong");

  gap_read_a: assert property ( // R15
    @(posedge core_clk_in) disable iff (!reset_n_in)
    rd_en_in && (addr_in == 16'h006f || addr_in == 16'h0072 || addr_in == 16'h0073)
    |=> rdata_out == 16'h0000)
    else $error("gap read nonzero");

  gap_wr_a: assert property ( // R15
    @(posedge core_clk_in) disable iff (!reset_n_in)
    wr_en_in && (addr_in == 16'h006f || addr_in == 16'h0072 || addr_in == 16'h0073)
    |=> $stable(sensor_r) && $stable(loss_r) && $stable(timeout_r) && $stable(mode_r)
    && $stable(unit_r) && $stable(source_r))
    else $error("gap write changed state");

  // main scenarios
  fire_c: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $rose(wd_fired_r));
  lost_c: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $rose(comm_lost_out));
  unit_c: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    wr_unit && wdata_in == 16'h0006);
  rearm_c: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    restart && wd_fired_r);
  gap_c: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    wr_en_in && addr_in == 16'h0072);
endmodule : vacr_regs
`default_nettype wire

// ==== include/vacr_pkg.sv ====
// vacr_pkg: constants for the valve actuator configuration register bank
//
// Contract
// R01 - sensor type codes 0,1,4; reset zero
// R02 - watchdog off by default; hold setpoint
// R03 - setpoint or force write restarts watchdog
// R04 - loss target codes 0..3; reset zero
// R05 - watchdog expiry sets malfunction status flag
// R06 - watchdog flag is status bit 10
// R07 - timeout 0..3600 seconds; zero disables
// R08 - timeout default 0, else 120 s
// R09 - 32-bit flow split low 112, high 113
// R10 - flow words follow current unit choice
// R11 - control mode 0 position, 1 flow
// R12 - unit codes 0..6; reset one
// R13 - setpoint source 0 analog, 1 bus; reset 1
// R14 - address 110 gives flow in m3/h
// R15 - addresses 111,114,115 read zero, ignore writes
// R16 - one-second tick drives counter; writes clear
package vacr_pkg;
  localparam logic [15:0] ADDR_STATUS = 16'h0068;
  localparam logic [15:0] ADDR_SENSOR = 16'h006b;
  localparam logic [15:0] ADDR_LOSS = 16'h006c;
  localparam logic [15:0] ADDR_TIMEOUT = 16'h006d;
  localparam logic [15:0] ADDR_FLOW_M3H = 16'h006e;
  localparam logic [15:0] ADDR_GAP0 = 16'h006f;
  localparam logic [15:0] ADDR_FLOW_LO = 16'h0070;
  localparam logic [15:0] ADDR_FLOW_HI = 16'h0071;
  localparam logic [15:0] ADDR_GAP1 = 16'h0072;
  localparam logic [15:0] ADDR_GAP2 = 16'h0073;
  localparam logic [15:0] ADDR_MODE = 16'h0074;
  localparam logic [15:0] ADDR_UNIT = 16'h0075;
  localparam logic [15:0] ADDR_SOURCE = 16'h0076;
  localparam int WDOG_BIT = 10;
  localparam logic [15:0] SENSOR_RST = 16'h0000;
  localparam logic [15:0] LOSS_RST = 16'h0000;
  localparam logic [15:0] TIMEOUT_RST = 16'h0000;
  localparam logic [15:0] TIMEOUT_ACTIVE_DEF = 16'h0078;
  localparam logic [15:0] TIMEOUT_MAX = 16'h0e10;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] UNIT_RST = 16'h0001;
  localparam logic [15:0] SOURCE_RST = 16'h0001;
  localparam logic [15:0] UNIT_MAX = 16'h0006;
  localparam logic [15:0] LOSS_MAX = 16'h0003;
  localparam int CLK_HZ = 40000000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  typedef enum logic [1:0] {LOSS_HOLD, LOSS_CLOSE, LOSS_OPEN, LOSS_MID} vacr_loss_e;
endpackage : vacr_pkg

// ==== logic/vacr_tick.sv ====
// vacr_tick: one-cycle enable pulse every PERIOD clock cycles
`timescale 1ns/1ps
`default_nettype none
module vacr_tick #(
  parameter int PERIOD = 40000000
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // tick
  output logic tick_out
);
  logic [31:0] cnt_r;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      cnt_r <= 32'h0;
      tick_out <= 1'b0;
    end else if (cnt_r == 32'(PERIOD - 1)) begin
      cnt_r <= 32'h0;
      tick_out <= 1'b1; // R16
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick_out <= 1'b0;
    end
  end
endmodule : vacr_tick
`default_nettype wire

// ==== dv/vacr_master.sv ====
// vacr_master: bus master model issuing register and supervised writes
`timescale 1ns/1ps
`default_nettype none
module vacr_master (
  // clock
  input wire logic core_clk_in,
  // register requests
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [15:0] addr_out,
  output logic [15:0] wdata_out,
  input wire logic [15:0] rdata_in,
  input wire logic rvalid_in,
  // supervised writes
  output logic setpoint_wr_out,
  output logic force_wr_out
);
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 16'h0000;
    wdata_out = 16'h0000;
    setpoint_wr_out = 1'b0;
    force_wr_out = 1'b0;
  end
  // released lines show the inverse so stale values never pass
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge core_clk_in);
    wr_en_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk_in);
    rd_en_out <= 1'b1;
    addr_out <= a;
    @(posedge core_clk_in);
    rd_en_out <= 1'b0;
    addr_out <= ~a;
    @(posedge core_clk_in);
    d = rvalid_in ? rdata_in : 16'hxxxx;
  endtask : rd
  task automatic kick(input logic sel);
    @(posedge core_clk_in);
    setpoint_wr_out <= !sel;
    force_wr_out <= sel;
    @(posedge core_clk_in);
    setpoint_wr_out <= 1'b0;
    force_wr_out <= 1'b0;
  endtask : kick
endmodule : vacr_master
`default_nettype wire

// ==== dv/test_vacr_regs.sv ====
// test_vacr_regs: self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module test_vacr_regs;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic wr_en, rd_en, sp_wr, fc_wr, rvalid, lost, mode;
  logic [15:0] addr, wdata, rdata, status;
  logic [2:0] sens_o, unit_o;
  logic [1:0] loss_o;
  logic src_o;
  logic [15:0] fault_bits = 16'h0202;
  logic [31:0] flow [7];
  logic [15:0] tab [6][3] = '{'{16'h006b, 16'h0004, 16'h0002}, '{16'h006c, 16'h0003, 16'h0004},
    '{16'h006d, 16'h0e10, 16'h0e11}, '{16'h0074, 16'h0001, 16'h0002},
    '{16'h0075, 16'h0006, 16'h0007}, '{16'h0076, 16'h0000, 16'h0002}};
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  always #12.5 core_clk_in = ~core_clk_in;
  initial for (int i = 0; i < 7; i++) flow[i] = {16'(i + 1), 16'(16'ha000 + i)};
  // short tick so a two-second timeout takes a handful of cycles
  vacr_regs #(.TICK_CYCLES(4), .FLOW_M3H(16'h00a5)) u_vacr_regs (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr),
    .wdata_in(wdata), .rdata_out(rdata), .rvalid_out(rvalid), .setpoint_wr_in(sp_wr),
    .force_wr_in(fc_wr), .flow_by_unit_in(flow), .fault_bits_in(fault_bits),
    .sensor_type_out(sens_o), .loss_target_out(loss_o), .flow_mode_out(mode),
    .flow_unit_out(unit_o), .bus_source_out(src_o), .comm_lost_out(lost), .status_out(status));
  vacr_master u_vacr_master (.core_clk_in(core_clk_in), .wr_en_out(wr_en), .rd_en_out(rd_en),
    .addr_out(addr), .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid),
    .setpoint_wr_out(sp_wr), .force_wr_out(fc_wr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    u_vacr_master.wr(a, d);
  endtask : wr
  task automatic rc(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    u_vacr_master.rd(a, d);
    chk(32'(d), 32'(e));
  endtask : rc
  task automatic t_reset();
    rc(vacr_pkg::ADDR_SENSOR, 16'h0000);
    rc(vacr_pkg::ADDR_LOSS, 16'h0000);
    rc(vacr_pkg::ADDR_TIMEOUT, 16'h0000);
    rc(vacr_pkg::ADDR_UNIT, 16'h0001);
    rc(vacr_pkg::ADDR_SOURCE, 16'h0001);
    rc(vacr_pkg::ADDR_MODE, 16'h0000);
    repeat (20) @(posedge core_clk_in);
    chk(32'(lost), 32'h0);
    wr(vacr_pkg::ADDR_LOSS, 16'h0002);
    rc(vacr_pkg::ADDR_TIMEOUT, 16'h0078);
  endtask : t_reset
  task automatic t_codes();
    wr(vacr_pkg::ADDR_SENSOR, 16'h0001);
    rc(vacr_pkg::ADDR_SENSOR, 16'h0001);
    for (int i = 0; i < 6; i++) begin
      wr(tab[i][0], tab[i][1]);
      wr(tab[i][0], tab[i][2]);
      rc(tab[i][0], tab[i][1]);
    end
    chk(32'(mode), 32'h1);
    chk(32'(sens_o), 32'h4);
    chk(32'(loss_o), 32'h3);
    chk(32'(unit_o), 32'h6);
    chk(32'(src_o), 32'h0);
  endtask : t_codes
  task automatic t_flow();
    for (int u = 0; u < 7; u++) begin
      wr(vacr_pkg::ADDR_UNIT, 16'(u));
      rc(vacr_pkg::ADDR_FLOW_LO, flow[u][15:0]);
      rc(vacr_pkg::ADDR_FLOW_HI, flow[u][31:16]);
    end
    wr(vacr_pkg::ADDR_FLOW_LO, 16'h1234);
    rc(vacr_pkg::ADDR_FLOW_LO, flow[6][15:0]);
    rc(vacr_pkg::ADDR_FLOW_M3H, 16'h00a5);
  endtask : t_flow
  task automatic t_gap();
    wr(vacr_pkg::ADDR_SENSOR, 16'h0001);
    foreach (tab[i]) begin
      wr(vacr_pkg::ADDR_GAP0 + 16'(i % 3 == 0 ? 0 : i % 3 + 2), 16'h0004);
      rc(vacr_pkg::ADDR_GAP0 + 16'(i % 3 == 0 ? 0 : i % 3 + 2), 16'h0000);
    end
    rc(vacr_pkg::ADDR_SENSOR, 16'h0001);
  endtask : t_gap
  task automatic t_wdog();
    wr(vacr_pkg::ADDR_LOSS, 16'h0001);
    wr(vacr_pkg::ADDR_TIMEOUT, 16'h0002);
    u_vacr_master.kick(1'b0);
    repeat (3) @(posedge core_clk_in);
    chk(32'(lost), 32'h0);
    for (int i = 0; i < 30 && status[10] !== 1'b1; i++) @(posedge core_clk_in);
    chk(32'(status), 32'h0602);
    chk(32'(lost), 32'h1);
    rc(vacr_pkg::ADDR_STATUS, 16'h0602);
    for (int i = 0; i < 8; i++) begin
      u_vacr_master.kick(i[0]);
      @(posedge core_clk_in);
      chk(32'(lost), 32'h0);
    end
    u_vacr_master.kick(1'b1);
    wr(vacr_pkg::ADDR_TIMEOUT, 16'h0000);
    repeat (40) @(posedge core_clk_in);
    chk(32'(status), 32'h0202);
  endtask : t_wdog
  task automatic complete_run();
    $display("errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (10) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_codes();
    t_flow();
    t_gap();
    t_wdog();
    complete_run();
  end
  // the whole sequence needs well under a thousand cycles
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
endmodule : test_vacr_regs
`default_nettype wire
